// ---- inc/sfpt_pkg.sv ----
// Package of constants and carrier types for the parameter table reader
package sfpt_pkg;

    // ------------------------------------------------------------------
    // Serial command framing
    // ------------------------------------------------------------------
    localparam logic [7:0] SFPT_PARAM_TABLE_READ_CMD = 8'h5A;
    localparam logic [5:0] SFPT_CMD_BITS = 6'h08;
    localparam logic [5:0] SFPT_ADDR_END = 6'h20;
    localparam logic [5:0] SFPT_HDR_BITS = 6'h28;
    localparam logic [2:0] SFPT_LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // Table window and filler
    // ------------------------------------------------------------------
    localparam logic [7:0] SFPT_TBL_FIRST = 8'h30;
    localparam logic [7:0] SFPT_TBL_LAST = 8'h53;
    localparam logic [7:0] SFPT_FILL = 8'hFF;

    // ------------------------------------------------------------------
    // First parameter word fields (bytes 30H to 32H)
    // ------------------------------------------------------------------
    localparam logic [1:0] SFPT_ERASE_4K_AVAIL = 2'h1;
    localparam logic [0:0] SFPT_WR_GRAN_64 = 1'h1;
    localparam logic [0:0] SFPT_WEN_VOLATILE = 1'h0;
    localparam logic [0:0] SFPT_WEN_OPSEL = 1'h0;
    localparam logic [2:0] SFPT_UNUSED3 = 3'h7;
    localparam logic [0:0] SFPT_FR_112_SUP = 1'h1;
    localparam logic [1:0] SFPT_ADDR_3B_ONLY = 2'h0;
    localparam logic [0:0] SFPT_DTR_SUP = 1'h0;
    localparam logic [0:0] SFPT_FR_122_SUP = 1'h1;
    localparam logic [0:0] SFPT_FR_144_SUP = 1'h1;
    localparam logic [0:0] SFPT_FR_114_SUP = 1'h1;
    localparam logic [0:0] SFPT_UNUSED1 = 1'h1;
    localparam logic [7:0] SFPT_ERASE_4K_OP = 8'h20;

    // Density: bits minus one, eight megabits
    localparam logic [31:0] SFPT_DENSITY = 32'h007FFFFF;

    // ------------------------------------------------------------------
    // Fast read descriptors: wait states [4:0], mode bits [7:5]
    // ------------------------------------------------------------------
    localparam logic [4:0] SFPT_144_WAIT = 5'h04;
    localparam logic [2:0] SFPT_144_MODE = 3'h2;
    localparam logic [7:0] SFPT_144_OP = 8'hEB;
    localparam logic [4:0] SFPT_114_WAIT = 5'h08;
    localparam logic [2:0] SFPT_114_MODE = 3'h0;
    localparam logic [7:0] SFPT_114_OP = 8'h6B;
    localparam logic [4:0] SFPT_112_WAIT = 5'h08;
    localparam logic [2:0] SFPT_112_MODE = 3'h0;
    localparam logic [7:0] SFPT_112_OP = 8'h3B;
    localparam logic [4:0] SFPT_122_WAIT = 5'h00;
    localparam logic [2:0] SFPT_122_MODE = 3'h4;
    localparam logic [7:0] SFPT_122_OP = 8'hBB;
    localparam logic [7:0] SFPT_WIDE_SUP = 8'hEE;
    localparam logic [7:0] SFPT_WIDE_DESC = 8'h00;
    localparam logic [7:0] SFPT_WIDE_OP = 8'hFF;

    // ------------------------------------------------------------------
    // Sector types: size as log2 bytes, zero means absent
    // ------------------------------------------------------------------
    localparam logic [7:0] SFPT_SECT1_SIZE = 8'h0C;
    localparam logic [7:0] SFPT_SECT1_OP = 8'h20;
    localparam logic [7:0] SFPT_SECT2_SIZE = 8'h0F;
    localparam logic [7:0] SFPT_SECT2_OP = 8'h52;
    localparam logic [7:0] SFPT_SECT3_SIZE = 8'h10;
    localparam logic [7:0] SFPT_SECT3_OP = 8'hD8;
    localparam logic [7:0] SFPT_SECT4_SIZE = 8'h00;
    localparam logic [7:0] SFPT_SECT4_OP = 8'hFF;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sfpt_serial_in_t;

    typedef struct packed {
        logic so;
        logic so_oe_n;
    } sfpt_serial_out_t;

    typedef struct packed {
        logic wait_present;
        logic mode_present;
    } sfpt_desc_caps_t;

    typedef struct packed {
        sfpt_desc_caps_t fr144;
        sfpt_desc_caps_t fr114;
        sfpt_desc_caps_t fr112;
        sfpt_desc_caps_t fr122;
    } sfpt_caps_t;

    // Zero wait or mode count means the feature is absent
    function automatic sfpt_desc_caps_t sfpt_desc_decode(input logic [7:0] desc);
        sfpt_desc_caps_t c;
        c.wait_present = (desc[4:0] != 5'h00);
        c.mode_present = (desc[7:5] != 3'h0);
        return c;
    endfunction

endpackage

// ---- logic/sfpt_rom.sv ----
// Byte lookup ROM of the basic flash parameter words
`timescale 1ns/1ps
module sfpt_rom
    import sfpt_pkg::*;
(
    input wire logic [7:0] addr,
    output logic [7:0] data
);

    // ------------------------------------------------------------------
    // Packed parameter words, low byte at the lowest address
    // ------------------------------------------------------------------
    localparam logic [31:0] WORD0 = {8'hFF,
        SFPT_UNUSED1, SFPT_FR_114_SUP, SFPT_FR_144_SUP, SFPT_FR_122_SUP,
        SFPT_DTR_SUP, SFPT_ADDR_3B_ONLY, SFPT_FR_112_SUP,
        SFPT_ERASE_4K_OP,
        SFPT_UNUSED3, SFPT_WEN_OPSEL, SFPT_WEN_VOLATILE, SFPT_WR_GRAN_64,
        SFPT_ERASE_4K_AVAIL};
    localparam logic [31:0] WORD2 = {SFPT_114_OP, SFPT_114_MODE, SFPT_114_WAIT,
        SFPT_144_OP, SFPT_144_MODE, SFPT_144_WAIT};
    localparam logic [31:0] WORD3 = {SFPT_122_OP, SFPT_122_MODE, SFPT_122_WAIT,
        SFPT_112_OP, SFPT_112_MODE, SFPT_112_WAIT};
    localparam logic [31:0] WORD4 = {24'hFFFFFF, SFPT_WIDE_SUP};
    localparam logic [31:0] WORD5 = {SFPT_WIDE_OP, SFPT_WIDE_DESC, 16'hFFFF};
    localparam logic [31:0] WORD7 = {SFPT_SECT2_OP, SFPT_SECT2_SIZE,
        SFPT_SECT1_OP, SFPT_SECT1_SIZE};
    localparam logic [31:0] WORD8 = {SFPT_SECT4_OP, SFPT_SECT4_SIZE,
        SFPT_SECT3_OP, SFPT_SECT3_SIZE};

    // Little-endian byte pick from a word
    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] lane);
        return w[lane*8 +: 8];
    endfunction

    wire logic in_table = (addr >= SFPT_TBL_FIRST) && (addr <= SFPT_TBL_LAST);
    wire logic [7:0] rel = addr - SFPT_TBL_FIRST;
    wire logic [1:0] lane = rel[1:0];
    logic [31:0] word;

    always_comb begin
        unique case (rel[5:2])
            4'h0: word = WORD0;
            4'h1: word = SFPT_DENSITY;
            4'h2: word = WORD2;
            4'h3: word = WORD3;
            4'h4: word = WORD4;
            4'h5: word = WORD5;
            4'h6: word = WORD5;
            4'h7: word = WORD7;
            4'h8: word = WORD8;
            default: word = {4{SFPT_FILL}};
        endcase
    end

    // Bytes outside the basic table read as filler; nothing can write them
    assign data = in_table ? pick(word, lane) : SFPT_FILL;

endmodule // sfpt_rom

// ---- logic/sfpt_reader.sv ----
// Serial reader of the discoverable parameter table
//
// Notes on behaviour
// - Erase size field reads 01b
// - Write granularity bit reads one
// - Volatile write enable bits read zero
// - Four kilobyte erase opcode reads 20H
// - Address width field reads three bytes
// - Double transfer rate flag reads zero
// - Fast read flags and unused bits read one
// - Quad IO descriptor 44H, opcode EBH
// - Quad output descriptor 08H, opcode 6BH
// - Dual output descriptor 08H, opcode 3BH
// - Dual IO descriptor 80H, opcode BBH
// - Wide modes reported unsupported
// - Sector size is power of two, zero absent
// - Sector types two to four values fixed
// - Unused fields read all ones, unwritable
// - Zero wait or mode count means absent
// - Only low address byte selects entry
`timescale 1ns/1ps
module sfpt_reader
    import sfpt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sfpt_serial_in_t pins_in,
    output sfpt_serial_out_t pins_out,
    output logic cmd_active,
    output logic data_phase,
    output logic [7:0] cur_addr,
    output sfpt_caps_t caps
);

    // ------------------------------------------------------------------
    // Framing states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFPT_IDLE,
        SFPT_HDR,
        SFPT_DATA,
        SFPT_IGNORE
    } sfpt_state_t;

    sfpt_state_t state_reg;
    sfpt_state_t state_next;
    logic sck_reg;
    logic [5:0] hdr_cnt_reg;
    logic [5:0] hdr_cnt_next;
    logic [7:0] op_reg;
    logic [7:0] op_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic [7:0] sr_reg;
    logic [7:0] sr_next;
    logic [2:0] bit_cnt_reg;
    logic [2:0] bit_cnt_next;
    logic so_reg;
    logic so_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic [7:0] rom_byte;

    // ------------------------------------------------------------------
    // Edge detection on the serial clock
    // ------------------------------------------------------------------
    // Pins are synchronous to clk, so one history flop is enough
    wire logic selected = !pins_in.cs_n;
    wire logic sck_rise = selected && pins_in.sck && !sck_reg;
    wire logic sck_fall = selected && !pins_in.sck && sck_reg;

    // ------------------------------------------------------------------
    // Header decode
    // ------------------------------------------------------------------
    wire logic [5:0] hdr_cnt_inc = hdr_cnt_reg + 6'h01;
    wire logic [7:0] op_shift = {op_reg[6:0], pins_in.si};
    wire logic [7:0] addr_shift = {addr_reg[6:0], pins_in.si};
    wire logic in_cmd = (hdr_cnt_reg < SFPT_CMD_BITS);
    // Upper address bytes shift through and are overwritten by the low byte
    wire logic in_addr = !in_cmd && (hdr_cnt_reg < SFPT_ADDR_END);
    wire logic cmd_done = (hdr_cnt_inc == SFPT_CMD_BITS);
    wire logic cmd_ok = (op_shift == SFPT_PARAM_TABLE_READ_CMD);
    // Dummy byte must be fully clocked before data leaves
    wire logic hdr_done = (hdr_cnt_inc == SFPT_HDR_BITS);
    wire logic byte_done = (bit_cnt_reg == SFPT_LAST_BIT);
    wire logic [7:0] addr_inc = addr_reg + 8'h01;

    // ------------------------------------------------------------------
    // Table lookup
    // ------------------------------------------------------------------
    sfpt_rom u_rom (
        .addr(addr_reg),
        .data(rom_byte)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        hdr_cnt_next = hdr_cnt_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        sr_next = sr_reg;
        bit_cnt_next = bit_cnt_reg;
        so_next = so_reg;
        oe_n_next = oe_n_reg;
        if (!selected) begin
            // Deselect ends any frame at once, even mid byte
            state_next = SFPT_IDLE;
            hdr_cnt_next = 6'h00;
            bit_cnt_next = 3'h0;
            oe_n_next = 1'b1;
        end else begin
            unique case (state_reg)
                SFPT_IDLE: begin
                    state_next = SFPT_HDR;
                    hdr_cnt_next = 6'h00;
                    if (sck_rise) begin
                        op_next = op_shift;
                        hdr_cnt_next = 6'h01;
                    end
                end
                SFPT_HDR: begin
                    if (sck_rise) begin
                        hdr_cnt_next = hdr_cnt_inc;
                        if (in_cmd) begin
                            op_next = op_shift;
                            if (cmd_done && !cmd_ok) begin
                                // Other commands belong to other blocks
                                state_next = SFPT_IGNORE;
                            end
                        end else if (in_addr) begin
                            addr_next = addr_shift;
                        end else if (hdr_done) begin
                            state_next = SFPT_DATA;
                            sr_next = rom_byte;
                            addr_next = addr_inc;
                            bit_cnt_next = 3'h0;
                        end
                    end
                end
                SFPT_DATA: begin
                    if (sck_fall) begin
                        so_next = sr_reg[7];
                        oe_n_next = 1'b0;
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        if (byte_done) begin
                            // Address wraps within the low byte
                            sr_next = rom_byte;
                            addr_next = addr_inc;
                        end else begin
                            sr_next = {sr_reg[6:0], 1'b0};
                        end
                    end
                end
                SFPT_IGNORE: begin
                    state_next = SFPT_IGNORE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SFPT_IDLE;
            sck_reg <= 1'b0;
            hdr_cnt_reg <= 6'h00;
            op_reg <= 8'h00;
            addr_reg <= 8'h00;
            sr_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            so_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            sck_reg <= pins_in.sck;
            hdr_cnt_reg <= hdr_cnt_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            sr_reg <= sr_next;
            bit_cnt_reg <= bit_cnt_next;
            so_reg <= so_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Capability summary
    // ------------------------------------------------------------------
    // Decoded from the same constants the ROM serves, so both agree
    localparam logic [7:0] DESC144 = {SFPT_144_MODE, SFPT_144_WAIT};
    localparam logic [7:0] DESC114 = {SFPT_114_MODE, SFPT_114_WAIT};
    localparam logic [7:0] DESC112 = {SFPT_112_MODE, SFPT_112_WAIT};
    localparam logic [7:0] DESC122 = {SFPT_122_MODE, SFPT_122_WAIT};

    assign caps.fr144 = sfpt_desc_decode(DESC144);
    assign caps.fr114 = sfpt_desc_decode(DESC114);
    assign caps.fr112 = sfpt_desc_decode(DESC112);
    assign caps.fr122 = sfpt_desc_decode(DESC122);

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pins_out.so = so_reg;
    assign pins_out.so_oe_n = oe_n_reg;
    assign cmd_active = (state_reg == SFPT_HDR) || (state_reg == SFPT_DATA);
    assign data_phase = (state_reg == SFPT_DATA);
    assign cur_addr = addr_reg;

endmodule // sfpt_reader

// ---- verification/sfpt_reader_chk.sv ----
// Concurrent checks on the ports of the parameter table reader
`timescale 1ns/1ps
module sfpt_reader_chk
    import sfpt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sfpt_serial_in_t pins_in,
    input wire sfpt_serial_out_t pins_out,
    input wire logic cmd_active,
    input wire logic data_phase,
    input wire logic [7:0] cur_addr,
    input wire sfpt_caps_t caps
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    reset_idle_a: assert property ($fell(rst) |->
        pins_out.so_oe_n && !cmd_active && !data_phase && cur_addr == 8'h00)
        else $error("outputs not idle after reset");
    deselect_oe_a: assert property (pins_in.cs_n |=> pins_out.so_oe_n)
        else $error("output enabled one cycle after deselect");
    deselect_idle_a: assert property (pins_in.cs_n |=> !cmd_active && !data_phase)
        else $error("command still active after deselect");
    oe_only_data_a: assert property (!pins_out.so_oe_n |-> data_phase)
        else $error("serial output driven outside data phase");
    data_in_cmd_a: assert property (data_phase |-> cmd_active)
        else $error("data phase without active command");
    caps_const_a: assert property (caps == 8'hE9)
        else $error("descriptor capability flags wrong");
    so_change_a: assert property (
        (!pins_out.so_oe_n && $past(!pins_out.so_oe_n) && $changed(pins_out.so)) |->
        ($past(pins_in.sck, 2) && !$past(pins_in.sck)))
        else $error("serial output changed away from a clock fall");
    oe_start_a: assert property ($fell(pins_out.so_oe_n) |->
        data_phase && $past(pins_in.sck, 2) && !$past(pins_in.sck))
        else $error("output enable not tied to first clock fall");
    addr_step_a: assert property (
        (data_phase && $past(data_phase) && $changed(cur_addr)) |->
        cur_addr == $past(cur_addr) + 8'h01)
        else $error("table address did not step by one");
    hdr_end_a: assert property ($rose(data_phase) |->
        $past(pins_in.sck) && !$past(pins_in.sck, 2))
        else $error("data phase not started by a clock rise");

    cover property ($rose(data_phase));
    cover property ($fell(pins_out.so_oe_n));
    cover property (data_phase && pins_in.cs_n);
    cover property (data_phase && cur_addr == 8'h00 && $past(cur_addr) == 8'hFF);
endmodule // sfpt_reader_chk

bind sfpt_reader sfpt_reader_chk chk (.clk(clk), .rst(rst), .pins_in(pins_in),
    .pins_out(pins_out), .cmd_active(cmd_active), .data_phase(data_phase),
    .cur_addr(cur_addr), .caps(caps));

// ---- verification/sfpt_host.sv ----
// Serial host model that issues table reads and collects the returned bytes
`timescale 1ns/1ps
module sfpt_host
    import sfpt_pkg::*;
(
    input wire logic clk,
    output sfpt_serial_in_t pins,
    input wire sfpt_serial_out_t pins_out
);
    logic [7:0] rx_q[$];
    logic oe_seen;

    initial begin
        pins = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0};
        oe_seen = 1'h0;
    end

    // Two clk cycles per half period, so the sampled clock never aliases
    task automatic bit_slot(input logic b, output logic so_bit);
        @(posedge clk);
        pins.sck <= 1'h0;
        pins.si <= b;
        repeat (2) @(posedge clk);
        so_bit = pins_out.so;
        if (pins_out.so_oe_n === 1'h0) oe_seen = 1'h1;
        pins.sck <= 1'h1;
        @(posedge clk);
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
        logic [39:0] hdr;
        logic [7:0] sh;
        logic b;
        hdr = {op, addr, 8'hA5};
        rx_q.delete();
        oe_seen = 1'h0;
        @(posedge clk);
        pins.cs_n <= 1'h0;
        for (int i = 39; i >= 0; i--) bit_slot(hdr[i], b);
        // Toggling input during output shows that writes cannot alter the table
        for (int i = 0; i < nbits; i++) begin
            bit_slot(i[0], b);
            sh = {sh[6:0], b};
            if (i % 8 == 7) rx_q.push_back(sh);
        end
        @(posedge clk);
        pins.cs_n <= 1'h1;
        pins.sck <= 1'h0;
        @(posedge clk);
        pins.si <= ~pins.si;
    endtask
endmodule // sfpt_host

// ---- verification/sfpt_reader_bench.sv ----
// Self-checking bench of the parameter table reader
`timescale 1ns/1ps
module sfpt_reader_bench
    import sfpt_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    sfpt_serial_in_t pins_in;
    sfpt_serial_out_t pins_out;
    logic cmd_active;
    logic data_phase;
    logic [7:0] cur_addr;
    sfpt_caps_t caps;
    int error_cnt = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    sfpt_host host (.clk(clk), .pins(pins_in), .pins_out(pins_out));
    sfpt_reader dut (.clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out),
        .cmd_active(cmd_active), .data_phase(data_phase), .cur_addr(cur_addr), .caps(caps));

    // ------------------------------------------------------------------
    // Expected table
    // ------------------------------------------------------------------
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [31:0] dens;
        logic [7:0] tbl [36];
        dens = 32'h007FFFFF;
        tbl = '{{3'h7, 1'h0, 1'h0, 1'h1, 2'h1}, 8'h20, {4'hF, 1'h0, 2'h0, 1'h1}, 8'hFF,
            dens[7:0], dens[15:8], dens[23:16], dens[31:24],
            {3'h2, 5'h04}, 8'hEB, {3'h0, 5'h08}, 8'h6B, {3'h0, 5'h08}, 8'h3B,
            {3'h4, 5'h00}, 8'hBB, 8'hEE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
            8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8,
            8'h00, 8'hFF};
        if (a >= 8'h30 && a <= 8'h53) return tbl[a - 8'h30];
        return 8'hFF;
    endfunction

    // Wait and mode presence of one fast read descriptor byte
    function automatic logic [1:0] cap2(input logic [7:0] a);
        logic [7:0] d;
        d = exp_byte(a);
        return {d[4:0] != 5'h00, d[7:5] != 3'h0};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic read_check(input logic [23:0] addr, input int n);
        host.frame(SFPT_PARAM_TABLE_READ_CMD, addr, n * 8);
        check(8'(host.rx_q.size()), 8'(n));
        for (int i = 0; i < n; i++) begin
            check(host.rx_q[i], exp_byte(addr[7:0] + 8'(i)));
        end
        check({7'h0, host.oe_seen}, 8'h01);
    endtask

    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'h1, 1'h0);
        test_done();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] lo;
        int n;
        logic [7:0] bad_ops [3];
        void'($urandom(32'hAEC9E6CD));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check({7'h0, pins_out.so_oe_n}, 8'h01);
        check(cur_addr, 8'h00);
        check(caps, {cap2(8'h38), cap2(8'h3A), cap2(8'h3C), cap2(8'h3E)});
        read_check({16'($urandom()), 8'h30}, 36);
        $display("Test whole table done");
        read_check({16'hFFFF, 8'hFE}, 4);
        $display("Test address wrap done");
        repeat (6) begin
            lo = 8'($urandom_range(8'h55, 8'h2A));
            n = $urandom_range(5, 1);
            read_check({16'($urandom()), lo}, n);
        end
        $display("Test random reads done");
        bad_ops = '{8'h03, 8'h5B, 8'hDA};
        foreach (bad_ops[k]) begin
            host.frame(bad_ops[k], 24'h000030, 16);
            check({7'h0, host.oe_seen}, 8'h00);
        end
        $display("Test wrong opcode done");
        host.frame(SFPT_PARAM_TABLE_READ_CMD, 24'h000038, 11);
        check(8'(host.rx_q.size()), 8'h01);
        check(host.rx_q[0], exp_byte(8'h38));
        read_check(24'h00003A, 2);
        $display("Test abort and back to back done");
        fork
            host.frame(SFPT_PARAM_TABLE_READ_CMD, 24'h000030, 64);
            begin
                repeat (100) @(posedge clk);
                rst <= 1'h1;
                repeat (2) @(posedge clk);
                rst <= 1'h0;
            end
        join
        read_check(24'h12344C, 8);
        $display("Test reset in mid frame done");
        test_done();
    end
endmodule // sfpt_reader_bench
